// ---- verilog/bcd_decoder.sv ----
// branch and control opcode decoder with a classic wishbone register port
// assumes one clock, software feeding instruction bytes one at a time through the byte register
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module bcd_decoder
  import bcd_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter logic [7:0] OVF_VECTOR = 8'h04
)(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic busLock,
  output logic instrDone,
  output bcd_event_t lastEvent
);

  if (ADDR_W < 6) begin : gChk
    $error("bcd_decoder: ADDR_W must be at least 6");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // reset release
  logic rstMeta;
  logic rstSync;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end
    else
    begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state
  bcd_state_t state;
  bcd_state_t next_state;
  logic [7:0] opcode;
  logic [7:0] modrm;
  logic [15:0] disp;
  logic [15:0] imm;
  logic [15:0] flags;
  logic [15:0] count;
  logic [15:0] ip;
  logic [15:0] target;
  logic repValid;
  logic repZ;
  logic segValid;
  logic [1:0] seg;

  ////////////////////////////////////////////////////////////////////////////////
  // wishbone decode
  wire [7:0] addr = 8'(adr_i);
  wire req = cyc_i & stb_i;
  wire inExec = (state == ST_EXEC);
  wire wrFire = req & we_i & ack_o;
  wire hitCtrl = (addr == REG_CTRL);
  wire hitByte = (addr == REG_BYTE);
  wire hitFlags = (addr == REG_FLAGS);
  wire hitCount = (addr == REG_COUNT);
  wire hitIp = (addr == REG_IP);
  wire byteWr = wrFire & hitByte & sel_i[0];
  wire abortWr = wrFire & hitCtrl & sel_i[0] & dat_i[0];
  wire [7:0] inByte = dat_i[7:0];
  wire [15:0] wrMask = {{8{sel_i[1]}}, {8{sel_i[0]}}};

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] mask,
                                        input logic [15:0] nv);
    merge = (old & ~mask) | (nv & mask);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // opcode classification
  function automatic bcd_class_t classify(input logic [7:0] op);
    classify = CLS_OTHER;
    if (op[7:4] == OP_COND_HI)
      classify = CLS_BRANCH;
    else if (op == OP_LOOP || op == OP_LOOP_EQ || op == OP_LOOP_NE)
      classify = CLS_LOOP;
    else if (op == OP_COUNT_EMPTY)
      classify = CLS_COUNT_ZERO;
    else if (op == OP_FAR_RET || op == OP_FAR_RET_IMM)
      classify = CLS_FAR_RET;
    else if (op == OP_INT_N || op == OP_INT_BREAK || op == OP_TRAP_OVF)
      classify = CLS_INT;
    else if (op == OP_TRAP_RET)
      classify = CLS_TRAP_RET;
    else if (op == OP_CARRY_CLR || op == OP_CARRY_INV || op == OP_CARRY_SET
             || op == OP_STEP_UP || op == OP_STEP_DOWN
             || op == OP_TRAP_MASK || op == OP_TRAP_UNMASK)
      classify = CLS_FLAG;
    else if (op[7:3] == OP_ESC_HI)
      classify = CLS_ESC;
    else if (op[7:2] == OP_SHIFT_HI)
      classify = CLS_SHIFT;
    else if (op == OP_LOCK || op[7:1] == OP_REP_HI
             || (op[7:5] == OP_SEG_HI && op[2:0] == OP_SEG_LO))
      classify = CLS_PREFIX;
  endfunction

  wire bcd_class_t inCls = classify(inByte);
  wire bcd_class_t curCls = classify(opcode);
  wire inNeedsModrm = (inCls == CLS_ESC) || (inCls == CLS_SHIFT);
  wire inImm2 = (inByte == OP_FAR_RET_IMM);
  wire inImm1 = (inCls == CLS_BRANCH) || (inCls == CLS_LOOP)
              || (inCls == CLS_COUNT_ZERO) || (inByte == OP_INT_N);
  wire [1:0] inMod = inByte[7:6];
  wire inDirect = (inMod == MOD_NODISP) && (inByte[2:0] == RM_DIRECT);
  wire inDisp2 = (inMod == MOD_DISP16) || inDirect;

  ////////////////////////////////////////////////////////////////////////////////
  // byte sequencing: opcode, then either addressing byte and displacement or an immediate, then execute
  always_comb
  begin
    next_state = state;
    case (state)
      ST_OPCODE:
        if (byteWr)
        begin
          if (inNeedsModrm)
            next_state = ST_MODRM;
          else if (inImm1 || inImm2)
            next_state = ST_IMM_LO;
          else
            next_state = ST_EXEC;
        end
      ST_MODRM:
        if (byteWr)
        begin
          if (inMod == MOD_DISP8 || inDisp2)
            next_state = ST_DISP_LO;
          else
            next_state = ST_EXEC;
        end
      ST_DISP_LO:
        if (byteWr)
          next_state = (modrm[7:6] == MOD_DISP8) ? ST_EXEC : ST_DISP_HI;
      ST_DISP_HI:
        if (byteWr)
          next_state = ST_EXEC;
      ST_IMM_LO:
        if (byteWr)
          next_state = (opcode == OP_FAR_RET_IMM) ? ST_IMM_HI : ST_EXEC;
      ST_IMM_HI:
        if (byteWr)
          next_state = ST_EXEC;
      ST_EXEC:
        next_state = ST_OPCODE;
      default:
        next_state = ST_OPCODE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // condition evaluation
  wire fC = flags[FLAG_CF];
  wire fZ = flags[FLAG_ZF];
  wire fS = flags[FLAG_SF];
  wire fO = flags[FLAG_OF];
  wire fP = flags[FLAG_PF];
  logic condBase;

  always_comb
  begin
    case (opcode[3:1])
      3'h0: condBase = fO;
      3'h1: condBase = fC;
      3'h2: condBase = fZ;
      3'h3: condBase = fC | fZ;
      3'h4: condBase = fS;
      3'h5: condBase = fP;
      3'h6: condBase = fS ^ fO;
      3'h7: condBase = (fS ^ fO) | fZ;
      default: condBase = 1'b0;
    endcase
  end

  // low opcode bit inverts the test
  wire condHolds = condBase ^ opcode[0];
  wire [15:0] countDec = count - 16'h0001;
  wire loopZeroOk = (opcode == OP_LOOP) || (opcode == OP_LOOP_EQ && fZ)
                  || (opcode == OP_LOOP_NE && !fZ);
  wire loopGo = (countDec != 16'h0000) && loopZeroOk;
  wire countEmpty = (count == 16'h0000);
  wire [15:0] shortDisp = {{8{imm[7]}}, imm[7:0]};
  wire [15:0] branchTarget = ip + shortDisp;

  ////////////////////////////////////////////////////////////////////////////////
  // execution of the assembled instruction
  logic [15:0] next_flags;
  logic [15:0] next_count;
  logic [15:0] next_ip;
  bcd_event_t next_event;

  always_comb
  begin
    next_flags = flags;
    next_count = count;
    next_ip = ip;
    next_event = '0;
    next_event.lockHeld = busLock;
    case (curCls)
      CLS_BRANCH:
        next_event.taken = condHolds;
      CLS_LOOP:
      begin
        next_count = countDec;
        next_event.taken = loopGo;
      end
      CLS_COUNT_ZERO:
        next_event.taken = countEmpty;
      CLS_FAR_RET:
        next_event.farRet = 1'b1;
      CLS_INT:
      begin
        next_event.intReq = (opcode != OP_TRAP_OVF) || fO;
        if (opcode == OP_INT_N)
          next_event.vector = imm[7:0];
        else if (opcode == OP_INT_BREAK)
          next_event.vector = VEC_BREAK;
        else
          next_event.vector = OVF_VECTOR;
      end
      CLS_TRAP_RET:
        next_event.trapRet = 1'b1;
      CLS_FLAG:
        case (opcode)
          OP_CARRY_CLR: next_flags[FLAG_CF] = 1'b0;
          OP_CARRY_INV: next_flags[FLAG_CF] = !fC;
          OP_CARRY_SET: next_flags[FLAG_CF] = 1'b1;
          OP_STEP_UP: next_flags[FLAG_DF] = 1'b0;
          OP_STEP_DOWN: next_flags[FLAG_DF] = 1'b1;
          OP_TRAP_MASK: next_flags[FLAG_IF] = 1'b0;
          OP_TRAP_UNMASK: next_flags[FLAG_IF] = 1'b1;
          default: next_flags = flags;
        endcase
      CLS_ESC:
        next_event.escape = 1'b1;
      CLS_PREFIX:
        next_event.lockHeld = busLock | (opcode == OP_LOCK);
      default:
        next_event.other = (curCls == CLS_OTHER);
    endcase
    if (next_event.taken)
      next_ip = branchTarget;
  end

  // target register: branch address, stack adjust, or operand offset for the coprocessor
  wire [15:0] next_target = (curCls == CLS_FAR_RET) ? imm
                          : (curCls == CLS_ESC) ? disp : branchTarget;

  ////////////////////////////////////////////////////////////////////////////////
  // byte capture
  always_ff @(posedge core_clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      state <= ST_OPCODE;
      opcode <= 8'h00;
      modrm <= 8'h00;
      disp <= 16'h0000;
      imm <= 16'h0000;
    end
    else
    begin
      state <= abortWr ? ST_OPCODE : next_state;
      if (byteWr && state == ST_OPCODE)
      begin
        opcode <= inByte;
        disp <= 16'h0000;
        imm <= 16'h0000;
      end
      if (byteWr && state == ST_MODRM)
        modrm <= inByte;
      if (byteWr && state == ST_DISP_LO)
        disp <= {{8{inByte[7]}}, inByte};
      if (byteWr && state == ST_DISP_HI)
        disp[15:8] <= inByte;
      if (byteWr && state == ST_IMM_LO)
        imm <= {8'h00, inByte};
      if (byteWr && state == ST_IMM_HI)
        imm[15:8] <= inByte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // architectural state; bus writes never land in the execute cycle
  always_ff @(posedge core_clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      flags <= FLAGS_RST;
      count <= COUNT_RST;
      ip <= IP_RST;
      target <= 16'h0000;
    end
    else if (inExec)
    begin
      flags <= next_flags;
      count <= next_count;
      ip <= next_ip;
      target <= next_target;
    end
    else
    begin
      if (wrFire && hitFlags)
        flags <= merge(flags, wrMask, dat_i[15:0]);
      if (wrFire && hitCount)
        count <= merge(count, wrMask, dat_i[15:0]);
      if (wrFire && hitIp)
        ip <= merge(ip, wrMask, dat_i[15:0]);
      else if (byteWr)
        ip <= ip + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // prefixes stay in force until the next non-prefix instruction completes or a control-register abort
  wire isPrefixExec = inExec && (curCls == CLS_PREFIX);
  wire endOfInstr = (inExec && (curCls != CLS_PREFIX)) || abortWr;

  always_ff @(posedge core_clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      busLock <= 1'b0;
      repValid <= 1'b0;
      repZ <= 1'b0;
      segValid <= 1'b0;
      seg <= SEG_EXTRA;
    end
    else if (isPrefixExec)
    begin
      if (opcode == OP_LOCK)
        busLock <= 1'b1;
      if (opcode[7:1] == OP_REP_HI)
      begin
        repValid <= 1'b1;
        repZ <= opcode[0];
      end
      if (opcode[7:5] == OP_SEG_HI)
      begin
        segValid <= 1'b1;
        seg <= opcode[4:3];
      end
    end
    else if (endOfInstr)
    begin
      busLock <= 1'b0;
      repValid <= 1'b0;
      segValid <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      instrDone <= 1'b0;
      lastEvent <= '0;
    end
    else
    begin
      instrDone <= inExec;
      if (inExec)
        lastEvent <= next_event;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // operand field view of the current instruction
  bcd_fields_t fields;
  wire shiftByCount = (curCls == CLS_SHIFT) && opcode[1];
  wire [7:0] shiftCount = shiftByCount ? count[7:0] : 8'h01;

  assign fields.cls = curCls;
  assign fields.wide = opcode[0];
  assign fields.toReg = opcode[1];
  assign fields.mode = modrm[7:6];
  assign fields.regF = modrm[5:3];
  assign fields.rmF = modrm[2:0];
  assign fields.rmIsReg = (modrm[7:6] == MOD_REG);
  assign fields.countByte = shiftByCount;
  assign fields.repZ = repZ & repValid;
  assign fields.seg = seg;
  assign fields.segValid = segValid;

  ////////////////////////////////////////////////////////////////////////////////
  // read mux and acknowledge
  wire [31:0] statusWord = {24'h0, 2'b00, repValid, busLock, 1'b0, 3'(state)};
  wire [31:0] fieldsWord = {4'h0, shiftCount, fields};
  wire [31:0] rdData = hitByte ? statusWord
                     : hitFlags ? {16'h0000, flags}
                     : hitCount ? {16'h0000, count}
                     : hitIp ? {16'h0000, ip}
                     : (addr == REG_FIELDS) ? fieldsWord
                     : (addr == REG_DISP) ? {16'h0000, disp}
                     : (addr == REG_EVENT) ? {17'h00000, lastEvent}
                     : (addr == REG_TARGET) ? {16'h0000, target}
                     : 32'h00000000;

  always_ff @(posedge core_clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end
    else
    begin
      ack_o <= req & ~ack_o & ~inExec;
      if (req && !ack_o && !inExec)
        dat_o <= rdData;
    end
  end

endmodule

`default_nettype wire

// ---- verilog/bcd_pkg.sv ----
// constants, field layouts and carrier types for the branch and control opcode decoder
// assumes a 32-bit classic wishbone slave port with word-aligned registers
package bcd_pkg;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_BYTE = 8'h04;
  localparam logic [7:0] REG_FLAGS = 8'h08;
  localparam logic [7:0] REG_COUNT = 8'h0C;
  localparam logic [7:0] REG_IP = 8'h10;
  localparam logic [7:0] REG_FIELDS = 8'h14;
  localparam logic [7:0] REG_DISP = 8'h18;
  localparam logic [7:0] REG_EVENT = 8'h1C;
  localparam logic [7:0] REG_TARGET = 8'h20;

  // flag word bit positions
  localparam int FLAG_CF = 0;
  localparam int FLAG_PF = 2;
  localparam int FLAG_ZF = 6;
  localparam int FLAG_SF = 7;
  localparam int FLAG_IF = 9;
  localparam int FLAG_DF = 10;
  localparam int FLAG_OF = 11;

  // reset values
  localparam logic [15:0] FLAGS_RST = 16'h0000;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] IP_RST = 16'h0000;

  // opcodes
  localparam logic [7:0] OP_FAR_RET = 8'hCB;
  localparam logic [7:0] OP_FAR_RET_IMM = 8'hCA;
  localparam logic [3:0] OP_COND_HI = 4'h7;
  localparam logic [7:0] OP_LOOP = 8'hE2;
  localparam logic [7:0] OP_LOOP_EQ = 8'hE1;
  localparam logic [7:0] OP_LOOP_NE = 8'hE0;
  localparam logic [7:0] OP_COUNT_EMPTY = 8'hE3;
  localparam logic [7:0] OP_INT_N = 8'hCD;
  localparam logic [7:0] OP_INT_BREAK = 8'hCC;
  localparam logic [7:0] OP_TRAP_OVF = 8'hCE;
  localparam logic [7:0] OP_TRAP_RET = 8'hCF;
  localparam logic [7:0] OP_CARRY_CLR = 8'hF8;
  localparam logic [7:0] OP_CARRY_INV = 8'hF5;
  localparam logic [7:0] OP_CARRY_SET = 8'hF9;
  localparam logic [7:0] OP_STEP_UP = 8'hFC;
  localparam logic [7:0] OP_STEP_DOWN = 8'hFD;
  localparam logic [7:0] OP_TRAP_MASK = 8'hFA;
  localparam logic [7:0] OP_TRAP_UNMASK = 8'hFB;
  localparam logic [7:0] OP_LOCK = 8'hF0;
  localparam logic [4:0] OP_ESC_HI = 5'b11011;
  localparam logic [5:0] OP_SHIFT_HI = 6'b110100;
  localparam logic [6:0] OP_REP_HI = 7'b1111001;
  localparam logic [2:0] OP_SEG_HI = 3'b001;
  localparam logic [2:0] OP_SEG_LO = 3'b110;
  localparam logic [7:0] VEC_BREAK = 8'h03;

  // addressing-form field
  localparam logic [1:0] MOD_NODISP = 2'b00;
  localparam logic [1:0] MOD_DISP8 = 2'b01;
  localparam logic [1:0] MOD_DISP16 = 2'b10;
  localparam logic [1:0] MOD_REG = 2'b11;
  localparam logic [2:0] RM_DIRECT = 3'b110;

  // register and segment codes
  localparam logic [2:0] REG_ACC = 3'b000;
  localparam logic [2:0] REG_CNT = 3'b001;
  localparam logic [2:0] REG_DATA = 3'b010;
  localparam logic [1:0] SEG_EXTRA = 2'b00;
  localparam logic [1:0] SEG_CODE = 2'b01;
  localparam logic [1:0] SEG_STACK = 2'b10;

  typedef enum logic [3:0] {
    CLS_NONE, CLS_BRANCH, CLS_LOOP, CLS_COUNT_ZERO, CLS_FAR_RET, CLS_INT,
    CLS_TRAP_RET, CLS_FLAG, CLS_ESC, CLS_SHIFT, CLS_PREFIX, CLS_OTHER
  } bcd_class_t;

  typedef enum {
    ST_OPCODE, ST_MODRM, ST_DISP_LO, ST_DISP_HI, ST_IMM_LO, ST_IMM_HI, ST_EXEC
  } bcd_state_t;

  // decoded operand fields, 20 bits
  typedef struct packed {
    bcd_class_t cls;
    logic wide;
    logic toReg;
    logic [1:0] mode;
    logic [2:0] regF;
    logic [2:0] rmF;
    logic rmIsReg;
    logic countByte;
    logic repZ;
    logic [1:0] seg;
    logic segValid;
  } bcd_fields_t;

  // result of the last executed instruction, 15 bits
  typedef struct packed {
    logic taken;
    logic intReq;
    logic farRet;
    logic trapRet;
    logic escape;
    logic lockHeld;
    logic other;
    logic [7:0] vector;
  } bcd_event_t;

endpackage

// ---- dv/bcd_decoder_sva.sv ----
// checker for the decoder's bus answer, completion, lock and event outputs
// assumes only the top-level ports; bound in after endmodule
`timescale 1ns/1ps
`default_nettype none
module bcd_decoder_sva
  import bcd_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic busLock,
  input wire logic instrDone,
  input wire bcd_event_t lastEvent
);
  logic byteAck;
  assign byteAck = ack_o && we_i && adr_i == REG_BYTE;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_lockRise;
    !busLock ##1 busLock;
  endsequence
  ////////////////////////////////////////////////////////////
  chk_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  chk_ack_answer: assert property (s_req |-> ##[1:2] ack_o)
    else $error("request not answered");
  chk_ack_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  chk_data_hold: assert property (!ack_o |-> $stable(dat_o))
    else $error("read data moved outside an answer");
  chk_done_pulse: assert property (instrDone |=> !instrDone)
    else $error("completion longer than one cycle");
  // execute follows the last byte write by one cycle, the pulse by one more
  chk_done_cause: assert property (instrDone |-> $past(byteAck, 2) || $past(byteAck, 3))
    else $error("completion without a byte write");
  chk_lock_rise: assert property (s_lockRise |-> instrDone)
    else $error("lock rose outside an execute");
  // an abort through the control register also ends the locked span
  chk_lock_fall: assert property ($fell(busLock) |-> instrDone ||
    $past(ack_o && we_i && adr_i == REG_CTRL))
    else $error("lock fell outside an execute or abort");
  chk_event_done: assert property ($changed(lastEvent) |-> instrDone)
    else $error("event changed without completion");
endmodule
bind bcd_decoder bcd_decoder_sva #(.ADDR_W(ADDR_W)) bcd_decoder_sva_i (.core_clk(core_clk),
  .rst_n(rst_n), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o),
  .ack_o(ack_o), .busLock(busLock), .instrDone(instrDone), .lastEvent(lastEvent));
`default_nettype wire

// ---- dv/tb_top.sv ----
// self-checking bench for the branch and control opcode decoder
// assumes the decoder is the only slave on a classic wishbone bus
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin mismatches++; \
  $display("BAD %s exp %0h got %0h", nm, e, s); end end
module tb_top;
  import bcd_pkg::*;
  logic clk = 1'b0;
  logic rstN = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] datO;
  logic [31:0] rdat;
  logic ack;
  logic busLock;
  logic instrDone;
  bcd_event_t lastEvent;
  int mismatches = 0;
  int num_checks = 0;
  // loop rows: opcode, count, zero flag, taken, count after
  logic [41:0] lp [8] = '{{OP_LOOP, 16'h0001, 2'b00, 16'h0000},
    {OP_LOOP, 16'h0002, 2'b01, 16'h0001}, {OP_LOOP_EQ, 16'h0003, 2'b11, 16'h0002},
    {OP_LOOP_EQ, 16'h0003, 2'b00, 16'h0002}, {OP_LOOP_NE, 16'h0003, 2'b10, 16'h0002},
    {OP_LOOP_NE, 16'h0003, 2'b01, 16'h0002}, {OP_COUNT_EMPTY, 16'h0000, 2'b01, 16'h0000},
    {OP_COUNT_EMPTY, 16'h0005, 2'b00, 16'h0005}};
  // flag rows: opcode, flags before, flags after
  logic [39:0] fo [8] = '{{OP_CARRY_CLR, 32'h00010000}, {OP_CARRY_INV, 32'h00010000},
    {OP_CARRY_INV, 32'h00000001}, {OP_CARRY_SET, 32'h00000001},
    {OP_STEP_UP, 32'h04000000}, {OP_STEP_DOWN, 32'h00000400},
    {OP_TRAP_MASK, 32'h02000000}, {OP_TRAP_UNMASK, 32'h00000200}};
  // control rows: bytes, count, overflow, taken/int/far/trap_return/esc, vector
  logic [48:0] ct [8] = '{{32'h21CD, 4'h4, 5'b01000, 8'h21}, {32'hCC, 4'h2, 5'b01000, 8'h03},
    {32'hCE, 4'h3, 5'b01000, 8'h04}, {32'hCE, 4'h2, 5'b00000, 8'h00},
    {32'hCF, 4'h2, 5'b00010, 8'h00}, {32'hCB, 4'h2, 5'b00100, 8'h00},
    {32'h123486D8, 4'h8, 5'b00001, 8'h00}, {32'h1234CA, 4'h6, 5'b00100, 8'h00}};
  // form rows: opcode and form byte, state, disp bytes, count, disp
  logic [52:0] ad [5] = '{{16'hC1D8, 3'h0, 18'h0, 16'h0000},
    {16'h00D8, 3'h0, 18'h0, 16'h0000}, {16'h45D8, 3'h2, 18'h00201, 16'hFF80},
    {16'h85D8, 3'h2, 18'h048D2, 16'h1234}, {16'h06D8, 3'h2, 18'h048D2, 16'h1234}};
  bcd_decoder bcd_decoder_i (.core_clk(clk), .rst_n(rstN), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(datO), .ack_o(ack),
    .busLock(busLock), .instrDone(instrDone), .lastEvent(lastEvent));
  initial
    forever #5 clk = ~clk;
  ////////////////////////////////////////////////////////////
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    @(posedge clk);
    // no cycle count is assumed here; only the watchdog ends a hung wait
    while (ack !== 1'b1)
      @(posedge clk);
    rdat = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic feed(input logic [31:0] b, input int n);
    for (int i = 0; i < n; i++)
      wb(1'b1, REG_BYTE, {24'h0, b[8*i+:8]});
  endtask
  function automatic logic condOk(input logic [3:0] c, input logic [15:0] f);
    logic r;
    case (c[3:1])
      3'h0: r = f[FLAG_OF];
      3'h1: r = f[FLAG_CF];
      3'h2: r = f[FLAG_ZF];
      3'h3: r = f[FLAG_CF] | f[FLAG_ZF];
      3'h4: r = f[FLAG_SF];
      3'h5: r = f[FLAG_PF];
      3'h6: r = f[FLAG_SF] ^ f[FLAG_OF];
      default: r = f[FLAG_ZF] | (f[FLAG_SF] ^ f[FLAG_OF]);
    endcase
    return r ^ c[0];
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    logic [15:0] fl;
    repeat (10) @(posedge clk);
    rstN <= 1'b1;
    repeat (3) @(posedge clk);
    wb(1'b0, REG_IP, 32'h0);
    `CHK("ip reset", IP_RST, rdat[15:0])
    wb(1'b0, 8'hF0, 32'h0);
    `CHK("unmapped", 32'h0, rdat)
    for (int c = 0; c < 16; c++)
      for (int k = 0; k < 3; k++)
      begin
        fl = (k == 0) ? 16'h0000 : (k == 1) ? 16'h08C5 : 16'h0080;
        wb(1'b1, REG_FLAGS, {16'h0, fl});
        wb(1'b1, REG_IP, 32'h100);
        feed({16'h0, 8'hF0, OP_COND_HI, c[3:0]}, 2);
        wb(1'b0, REG_IP, 32'h0);
        `CHK("ip", condOk(c[3:0], fl) ? 16'h00F2 : 16'h0102, rdat[15:0])
        `CHK("taken", condOk(c[3:0], fl), lastEvent.taken)
      end
    $display("test branches done");
    foreach (lp[i])
    begin
      wb(1'b1, REG_COUNT, {16'h0, lp[i][33:18]});
      wb(1'b1, REG_FLAGS, {25'h0, lp[i][17], 6'h0});
      feed({16'h0, 8'h05, lp[i][41:34]}, 2);
      wb(1'b0, REG_COUNT, 32'h0);
      `CHK("count", lp[i][15:0], rdat[15:0])
      `CHK("loop taken", lp[i][16], lastEvent.taken)
    end
    foreach (fo[i])
    begin
      wb(1'b1, REG_FLAGS, {16'h0, fo[i][31:16]});
      feed({24'h0, fo[i][39:32]}, 1);
      wb(1'b0, REG_FLAGS, 32'h0);
      `CHK("flag op", fo[i][15:0], rdat[15:0])
    end
    $display("test loops and flags done");
    foreach (ct[i])
    begin
      wb(1'b1, REG_FLAGS, {20'h0, ct[i][13], 11'h0});
      feed(ct[i][48:17], int'(ct[i][16:14]));
      wb(1'b0, REG_TARGET, 32'h0);
      `CHK("event", ct[i][12:8], lastEvent[14:10])
      if (ct[i][11])
        `CHK("vector", ct[i][7:0], lastEvent.vector)
    end
    `CHK("adjust", 16'h1234, rdat[15:0])
    $display("test control done");
    foreach (ad[i])
    begin
      feed({16'h0, ad[i][52:37]}, 2);
      wb(1'b0, REG_BYTE, 32'h0);
      `CHK("state", ad[i][36:34], rdat[2:0])
      feed({16'h0, ad[i][33:18]}, int'(ad[i][17:16]));
      wb(1'b0, REG_DISP, 32'h0);
      `CHK("disp", ad[i][15:0], rdat[15:0])
    end
    wb(1'b1, REG_COUNT, 32'h7);
    feed(32'hC1D3, 2);
    wb(1'b0, REG_FIELDS, 32'h0);
    `CHK("count src", 14'h01FF, {rdat[27:20], rdat[15:12], rdat[5:4]})
    feed(32'hC8D0, 2);
    wb(1'b0, REG_FIELDS, 32'h0);
    `CHK("one", 12'h011, {rdat[27:20], rdat[15], rdat[11:9]})
    feed(32'hF336, 2);
    wb(1'b0, REG_FIELDS, 32'h0);
    `CHK("prefix", 4'hD, rdat[3:0])
    feed(32'hF0, 1);
    wb(1'b0, REG_BYTE, 32'h0);
    `CHK("lock on", 1'b1, busLock)
    feed(32'hF8, 1);
    wb(1'b0, REG_BYTE, 32'h0);
    `CHK("lock off", 2'b01, {busLock, lastEvent.lockHeld})
    feed(32'h74F0, 2);
    wb(1'b0, REG_BYTE, 32'h0);
    `CHK("partial", 5'h14, rdat[4:0])
    wb(1'b1, REG_CTRL, 32'h1);
    wb(1'b0, REG_BYTE, 32'h0);
    `CHK("abort", 6'h00, {busLock, rdat[4:0]})
    $display("test fields done");
    tally_and_finish();
  end
  initial
  begin
    repeat (30000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
